// ===== verilog/dsar_channel.sv

module dsar_channel
   import dsar_pkg::*;
(
   input  wire logic        clk_i,        // system clock
   input  wire logic        rst_i,        // synchronous reset
   // wishbone slave
   input  wire logic        wb_cyc_i,     // cycle
   input  wire logic        wb_stb_i,     // strobe
   input  wire logic        wb_we_i,      // write enable
   input  wire logic [7:0]  wb_adr_i,     // byte address
   input  wire logic [3:0]  wb_sel_i,     // byte lanes
   input  wire logic [31:0] wb_dat_i,     // write data
   output logic      [31:0] wb_dat_o,     // read data
   output logic             wb_ack_o,     // acknowledge
   // activation requests, one-cycle pulses except the external pin (edge detected)
   input  wire logic [3:0]  tmr_req_i,    // timer compare/capture a
   input  wire logic        txe_req_i,    // serial transmit empty
   input  wire logic        rxf_req_i,    // serial receive full
   input  wire logic        ext_req_i,    // external request pin
   // system bus master
   output logic [23:0]      sb_adr_o,     // bus address
   output logic             sb_req_o,     // bus request
   output logic             sb_we_o,      // write cycle
   output logic             sb_word_o,    // word sized cycle
   output logic [15:0]      sb_dat_o,     // write data
   input  wire logic        sb_ack_i,     // bus acknowledge
   input  wire logic [15:0] sb_dat_i,     // read data
   output logic             irq_o         // interrupt level
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // programmed state
   logic [MEM_AW-1:0]   memory_address_pointer_r;
   logic [IO_LOW_W-1:0] io_low_address_r;
   logic [CNT_W-1:0]    transfer_counter_word_r;
   logic                channel_transfer_enable_r;
   logic                element_size_select_r;
   logic                address_direction_select_r;
   logic                repeat_mode_r;
   logic [CTL_SRC_W-1:0] src_sel_r;
   logic [ST_W-1:0]     status_r;
   logic [ST_W-1:0]     mask_r;

   // sequencer state
   dsar_state_t         state_r;
   logic                to_mem_r;

   // external pin synchroniser
   logic                ext_s1_r;
   logic                ext_s2_r;
   logic                ext_s3_r;

   // decoded strobes
   logic                bus_hit;
   logic                wr_ctl;
   logic                wr_mask;
   logic                rd_status;
   logic [31:0]         rd_data;
   logic                req_pulse;
   logic                done_pulse;
   logic                xfer_pulse;
   logic [ST_W-1:0]     status_set;

   // derived counts and addresses
   logic [7:0]          repeat_running_count;
   logic [7:0]          repeat_initial_count;
   logic                repeat_wrap;
   logic [MEM_AW-1:0]   step;
   logic [MEM_AW-1:0]   rewind;
   logic [MEM_AW-1:0]   io_full_addr;

   // ---------------------------------------------------------------
   // decoded strobes and derived addresses
   // ---------------------------------------------------------------
   assign repeat_running_count = transfer_counter_word_r[15:8];
   assign repeat_initial_count = transfer_counter_word_r[7:0];
   // running count wraps at one, zero tolerated
   assign repeat_wrap = (repeat_running_count == 8'h01)
                        | (repeat_running_count == BYTE_ZERO);
   assign bus_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctl    = bus_hit & wb_we_i & (wb_adr_i == ADDR_CONTROL)
                      & wb_sel_i[0];
   assign wr_mask   = bus_hit & wb_we_i & (wb_adr_i == ADDR_MASK)
                      & wb_sel_i[0];
   assign rd_status = bus_hit & ~wb_we_i & (wb_adr_i == ADDR_STATUS);

   assign io_full_addr = {IO_HIGH, io_low_address_r};

   // size of one element in bytes
   assign step = element_size_select_r ? 24'h000002 : 24'h000001;
   // initial count times element size
   assign rewind = element_size_select_r ?
                   {15'h0000, repeat_initial_count, 1'b0} :
                   {16'h0000, repeat_initial_count};

   // ---------------------------------------------------------------
   // external request synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_req_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // ---------------------------------------------------------------
   // activation select
   // ---------------------------------------------------------------
   // source multiplexer
   always_comb begin
      case (src_sel_r)
         SRC_TMR0: req_pulse = tmr_req_i[0];
         SRC_TMR1: req_pulse = tmr_req_i[1];
         SRC_TMR2: req_pulse = tmr_req_i[2];
         SRC_TMR3: req_pulse = tmr_req_i[3];
         SRC_TXE:  req_pulse = txe_req_i;
         SRC_RXF:  req_pulse = rxf_req_i;
         SRC_EXT:  req_pulse = ext_s2_r & ~ext_s3_r;
         default:  req_pulse = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // transfer sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= ST_IDLE;
         sb_req_o  <= 1'b0;
         sb_we_o   <= 1'b0;
         sb_word_o <= 1'b0;
         sb_adr_o  <= PTR_RST;
         sb_dat_o  <= WORD_ZERO;
         to_mem_r  <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (req_pulse & channel_transfer_enable_r) begin
                  to_mem_r  <= (src_sel_r == SRC_RXF);
                  sb_adr_o  <= (src_sel_r == SRC_RXF) ? io_full_addr :
                               memory_address_pointer_r;
                  sb_req_o  <= 1'b1;
                  sb_we_o   <= 1'b0;
                  sb_word_o <= element_size_select_r;
                  state_r   <= ST_READ;
               end
            end

            ST_READ: begin
               if (sb_ack_i) begin
                  sb_dat_o <= sb_dat_i;
                  sb_adr_o <= to_mem_r ? memory_address_pointer_r :
                              io_full_addr;
                  sb_we_o  <= 1'b1;
                  state_r  <= ST_WRITE;
               end
            end

            ST_WRITE: begin
               if (sb_ack_i) begin
                  sb_req_o <= 1'b0;
                  sb_we_o  <= 1'b0;
                  state_r  <= ST_IDLE;
               end
            end

            default: begin
               sb_req_o <= 1'b0;
               state_r  <= ST_IDLE;
            end
         endcase
      end
   end

   assign xfer_pulse = (state_r == ST_WRITE) & sb_ack_i;
   // idle run ends when word hits zero
   assign done_pulse = xfer_pulse & ~repeat_mode_r
                       & (transfer_counter_word_r == 16'h0001);
   assign status_set = {xfer_pulse, done_pulse};

   // ---------------------------------------------------------------
   // address and count registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         memory_address_pointer_r <= PTR_RST;
         transfer_counter_word_r  <= CNT_RST;
      end else if (bus_hit & wb_we_i) begin
         case (wb_adr_i)
            ADDR_MEM_PTR: begin
               if (wb_sel_i[0]) memory_address_pointer_r[7:0]   <=
                  wb_dat_i[7:0];
               if (wb_sel_i[1]) memory_address_pointer_r[15:8]  <=
                  wb_dat_i[15:8];
               if (wb_sel_i[2]) memory_address_pointer_r[23:16] <=
                  wb_dat_i[23:16];
            end

            ADDR_COUNTER: begin
               if (wb_sel_i[0]) transfer_counter_word_r[7:0]  <=
                  wb_dat_i[7:0];
               if (wb_sel_i[1]) transfer_counter_word_r[15:8] <=
                  wb_dat_i[15:8];
            end

            default: ;
         endcase
      end else if (xfer_pulse) begin
         if (repeat_mode_r) begin
            if (repeat_wrap) begin
               transfer_counter_word_r[15:8] <= repeat_initial_count;
               // rewind by initial count times size
               memory_address_pointer_r <= address_direction_select_r ?
                  memory_address_pointer_r - step + rewind :
                  memory_address_pointer_r + step - rewind;
            end else begin
               transfer_counter_word_r[15:8] <=
                  repeat_running_count - 8'h01;
               memory_address_pointer_r <= address_direction_select_r ?
                  memory_address_pointer_r - step :
                  memory_address_pointer_r + step;
            end
         end else begin
            // one count per element, zero wraps
            transfer_counter_word_r <= transfer_counter_word_r - 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // io low address register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_low_address_r <= IO_RST;
      end else if (bus_hit & wb_we_i & (wb_adr_i == ADDR_IO_LOW)
                   & wb_sel_i[0]) begin
         io_low_address_r <= wb_dat_i[7:0];
      end
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_transfer_enable_r <= 1'b0;
      end else if (done_pulse) begin
         // hardware clear wins over a write
         channel_transfer_enable_r <= 1'b0;
      end else if (wr_ctl) begin
         channel_transfer_enable_r <= wb_dat_i[CTL_ENABLE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // mode bits
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         element_size_select_r      <= 1'b0;
         address_direction_select_r <= 1'b0;
         repeat_mode_r              <= 1'b0;
         src_sel_r                  <= SRC_TMR0;
      end else if (wr_ctl) begin
         element_size_select_r      <= wb_dat_i[CTL_SIZE_BIT];
         address_direction_select_r <= wb_dat_i[CTL_DIR_BIT];
         repeat_mode_r              <= wb_dat_i[CTL_REPEAT_BIT];
         src_sel_r <= wb_dat_i[CTL_SRC_LSB +: CTL_SRC_W];
      end
   end

   // ---------------------------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= 2'b00;
      end else begin
         // done only raised in idle mode; set beats clear
         status_r <= (rd_status ? 2'b00 : status_r) | status_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= 2'b00;
      end else if (wr_mask) begin
         mask_r <= wb_dat_i[ST_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_r & mask_r);
      end
   end

   // ---------------------------------------------------------------
   // wishbone read and acknowledge
   // ---------------------------------------------------------------
   always_comb begin
      case (wb_adr_i)
         ADDR_MEM_PTR: rd_data = {8'h00, memory_address_pointer_r};
         ADDR_IO_LOW:  rd_data = {24'h000000, io_low_address_r};
         ADDR_COUNTER: rd_data = {16'h0000, transfer_counter_word_r};
         ADDR_CONTROL: rd_data = {25'h0000000, src_sel_r,
                                  repeat_mode_r,
                                  address_direction_select_r,
                                  element_size_select_r,
                                  channel_transfer_enable_r};
         ADDR_STATUS:  rd_data = {30'h00000000, status_r};
         ADDR_MASK:    rd_data = {30'h00000000, mask_r};
         default:      rd_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_dat_o <= bus_hit ? rd_data : 32'h00000000;
      end
   end

endmodule : dsar_channel

// ===== verilog/dsar_pkg.sv
package dsar_pkg;

   // ---------------------------------------------------------------
   // register map (word offsets, byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_MEM_PTR  = 8'h00;
   localparam logic [7:0] ADDR_IO_LOW   = 8'h04;
   localparam logic [7:0] ADDR_COUNTER  = 8'h08;
   localparam logic [7:0] ADDR_CONTROL  = 8'h0c;
   localparam logic [7:0] ADDR_STATUS   = 8'h10;
   localparam logic [7:0] ADDR_MASK     = 8'h14;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_SIZE_BIT   = 1;
   localparam int CTL_DIR_BIT    = 2;
   localparam int CTL_REPEAT_BIT = 3;
   localparam int CTL_SRC_LSB    = 4;
   localparam int CTL_SRC_W      = 3;

   // status / mask fields
   localparam int ST_DONE_BIT = 0;
   localparam int ST_XFER_BIT = 1;
   localparam int ST_W        = 2;

   // ---------------------------------------------------------------
   // activation sources
   // ---------------------------------------------------------------
   localparam logic [2:0] SRC_TMR0 = 3'h0;
   localparam logic [2:0] SRC_TMR1 = 3'h1;
   localparam logic [2:0] SRC_TMR2 = 3'h2;
   localparam logic [2:0] SRC_TMR3 = 3'h3;
   localparam logic [2:0] SRC_TXE  = 3'h4;
   localparam logic [2:0] SRC_RXF  = 3'h5;
   localparam logic [2:0] SRC_EXT  = 3'h6;
   localparam int         NUM_SRC  = 7;

   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int          MEM_AW    = 24;
   localparam int          IO_LOW_W  = 8;
   localparam int          CNT_W     = 16;
   localparam logic [15:0] IO_HIGH   = 16'hffff;
   localparam logic [23:0] PTR_RST   = 24'h000000;
   localparam logic [7:0]  IO_RST    = 8'h00;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } dsar_state_t;

endpackage : dsar_pkg

// ===== verif/dsar_mem_model.sv
module dsar_mem_model (
   input  wire logic        clk_i,    // clock
   input  wire logic        rst_i,    // reset
   input  wire logic        sb_req_i, // bus request
   input  wire logic [23:0] sb_adr_i, // bus address
   output logic             sb_ack_o, // bus ack
   output logic [15:0]      sb_dat_o  // read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_r;
   // ---------------------------------------------------------------
   // ack after 0..3 wait cycles, data churns when not acking
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sb_ack_o <= 1'b0;
         sb_dat_o <= 16'h0000;
         wait_r   <= 2'h0;
      end else if (sb_req_i && !sb_ack_o && wait_r == 2'h0) begin
         sb_ack_o <= 1'b1;
         sb_dat_o <= sb_adr_i[15:0] ^ 16'h5a3c;
         wait_r   <= 2'($urandom_range(3));
      end else begin
         sb_ack_o <= 1'b0;
         sb_dat_o <= ~sb_dat_o;
         if (sb_req_i && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end
      end
   end
endmodule : dsar_mem_model

// ===== verif/dsar_checker.sv
module dsar_checker
   import dsar_pkg::*;
(
   input wire logic        clk_i,     // clock
   input wire logic        rst_i,     // reset
   input wire logic        wb_cyc_i,  // cycle
   input wire logic        wb_stb_i,  // strobe
   input wire logic        wb_we_i,   // write
   input wire logic [7:0]  wb_adr_i,  // address
   input wire logic        wb_ack_o,  // ack
   input wire logic [3:0]  tmr_req_i, // timers
   input wire logic        txe_req_i, // tx empty
   input wire logic        rxf_req_i, // rx full
   input wire logic        ext_req_i, // ext pin
   input wire logic [23:0] sb_adr_o,  // bus address
   input wire logic        sb_req_o,  // bus request
   input wire logic        sb_we_o,   // bus write
   input wire logic        sb_ack_i,  // bus ack
   input wire logic        irq_o      // interrupt
);
   logic [23:0] rd_adr_r;
   logic [3:0]  ext_age_r;
   always_ff @(posedge clk_i) begin
      if (sb_req_o && !sb_we_o && sb_ack_i) begin
         rd_adr_r <= sb_adr_o;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_age_r <= 4'hf;
      end else if (ext_req_i) begin
         ext_age_r <= 4'h0;
      end else if (ext_age_r != 4'hf) begin
         ext_age_r <= ext_age_r + 4'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   AST_WB_ACK: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("register ack missing");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("register ack too long");
   AST_READ_FIRST: assert property ($rose(sb_req_o) |-> !sb_we_o)
      else $error("bus cycle not starting with read");
   AST_WRITE_AFTER_READ: assert property (
      sb_req_o && !sb_we_o && sb_ack_i |=> sb_req_o && sb_we_o)
      else $error("write phase missing");
   AST_REQ_END: assert property (
      sb_req_o && sb_we_o && sb_ack_i |=> !sb_req_o)
      else $error("request held after write");
   AST_REQ_HOLD: assert property (
      sb_req_o && !sb_ack_i |=> sb_req_o && $stable(sb_adr_o)
         && $stable(sb_we_o))
      else $error("bus request changed before ack");
   AST_SRC_CAUSE: assert property ($rose(sb_req_o) |->
      $past(|tmr_req_i || txe_req_i || rxf_req_i) || ext_age_r < 4'h8)
      else $error("bus cycle without activation");
   AST_IO_HIGH: assert property (sb_req_o && sb_we_o && sb_ack_i |->
      rd_adr_r[23:8] == IO_HIGH || sb_adr_o[23:8] == IO_HIGH)
      else $error("io address upper bits not ones");
   AST_IRQ_CLEAR: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i == ADDR_STATUS |-> ##[1:3] !irq_o)
      else $error("interrupt stays after status read");
   cover property (sb_req_o && sb_we_o && sb_ack_i);
   cover property ($rose(irq_o));
   cover property ($fell(sb_req_o) ##[1:8] $rose(sb_req_o));
endmodule : dsar_checker

// ===== verif/tb_dma_short_addr_idle_repeat.sv
module tb_dma_short_addr_idle_repeat;
   import dsar_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        we;
      logic [23:0] adr;
      logic        word;
      logic [15:0] dat;
   } dsar_note_t;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, l;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic        txe_req_i, rxf_req_i, ext_req_i, irq_o, sb_ack_i;
   logic        sb_req_o, sb_we_o, sb_word_o, w, dir;
   logic [3:0]  tmr_req_i;
   logic [23:0] sb_adr_o, m, a;
   logic [15:0] sb_dat_o, sb_dat_i;
   logic [2:0]  s;
   int          n_errors, cmp_count, n, st;
   dsar_note_t  exp_q[$];
   dsar_channel dut_u (.wb_sel_i(4'hf), .*);
   dsar_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .sb_req_i(sb_req_o),
      .sb_adr_i(sb_adr_o), .sb_ack_o(sb_ack_i), .sb_dat_o(sb_dat_i));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic fail(input string msg);
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
   endtask : fail
   task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) fail($sformatf("reg exp %h got %h", e, g));
   endtask : cmp_reg
   task automatic cmp_bus(input dsar_note_t g);
      dsar_note_t e;
      cmp_count++;
      if (exp_q.size() == 0) begin
         fail("unexpected bus cycle");
      end else begin
         e = exp_q.pop_front();
         if (!e.we) g.dat = e.dat;
         else if (!e.word) g.dat[15:8] = e.dat[15:8];
         if (g !== e) fail($sformatf("bus exp %h got %h", e, g));
      end
   endtask : cmp_bus
   task automatic wb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= wr;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic note(logic rx, logic [23:0] mp, logic wd);
      logic [23:0] io;
      io = {IO_HIGH, l};
      exp_q.push_back({1'b0, rx ? io : mp, wd, 16'h0000});
      exp_q.push_back({1'b1, rx ? mp : io, wd,
                       (rx ? io[15:0] : mp[15:0]) ^ 16'h5a3c});
   endtask : note
   task automatic fire(input logic [2:0] src, input bit go);
      int  t;
      bit  seen;
      @(posedge clk_i);
      {ext_req_i, rxf_req_i, txe_req_i, tmr_req_i} <= 7'h01 << src;
      repeat (src == SRC_EXT ? 3 : 1) @(posedge clk_i);
      {ext_req_i, rxf_req_i, txe_req_i, tmr_req_i} <= 7'h00;
      t = 0;
      seen = 0;
      while (t < 60 && !(seen && sb_req_o === 1'b0)) begin
         @(posedge clk_i);
         seen |= (sb_req_o === 1'b1);
         t++;
      end
      if (go && !seen) fail("transfer timeout");
   endtask : fire
   task automatic give_verdict();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clk_i) begin
      if (rst_i === 1'b0 && sb_req_o === 1'b1 && sb_ack_i === 1'b1) begin
         cmp_bus({sb_we_o, sb_adr_o, sb_word_o, sb_dat_o});
      end
   end
   initial begin
      #100us;
      fail("watchdog");
      give_verdict();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
      {wb_adr_i, wb_dat_i, ext_req_i, rxf_req_i, txe_req_i} = '0;
      tmr_req_i = 4'h0;
      n_errors = 0;
      cmp_count = 0;
      void'($urandom(32'h0e2ae6dd));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      m = 24'($urandom) & 24'h7ffffe;
      l = 8'($urandom);
      wb(1'b1, 8'h18, 32'hffffffff);
      wb(1'b0, 8'h18, 32'h0);
      cmp_reg(32'h0, q);
      wb(1'b1, ADDR_MEM_PTR, {8'h00, m});
      wb(1'b0, ADDR_MEM_PTR, 32'h0);
      cmp_reg({8'h00, m}, q);
      wb(1'b1, ADDR_IO_LOW, {24'h0, l});
      wb(1'b1, ADDR_COUNTER, 32'h7);
      for (int i = 0; i < NUM_SRC; i++) begin
         s = 3'(i);
         wb(1'b1, ADDR_CONTROL, {25'h0, s, 2'b00, s[0], 1'b1});
         note(s == SRC_RXF, m, s[0]);
         fire(s, 1);
      end
      wb(1'b0, ADDR_CONTROL, 32'h0);
      cmp_reg(32'h60, q);
      wb(1'b0, ADDR_MEM_PTR, 32'h0);
      cmp_reg({8'h00, m}, q);
      fire(SRC_TMR0, 0);
      cmp_reg(32'h0, {31'h0, irq_o});
      wb(1'b1, ADDR_MASK, 32'h1);
      repeat (2) @(posedge clk_i);
      cmp_reg(32'h1, {31'h0, irq_o});
      wb(1'b0, ADDR_STATUS, 32'h0);
      cmp_reg(32'h3, q);
      repeat (3) @(posedge clk_i);
      cmp_reg(32'h0, {31'h0, irq_o});
      wb(1'b1, ADDR_COUNTER, 32'h0);
      wb(1'b1, ADDR_CONTROL, 32'h1);
      note(1'b0, m, 1'b0);
      fire(SRC_TMR0, 1);
      wb(1'b0, ADDR_COUNTER, 32'h0);
      cmp_reg(32'hffff, q);
      wb(1'b0, ADDR_CONTROL, 32'h0);
      cmp_reg(32'h1, q);
      for (int c = 0; c < 2; c++) begin
         s = c ? SRC_RXF : 3'($urandom_range(3));
         n = c ? 2 : 3;
         w = !c;
         dir = !c;
         st = w ? 2 : 1;
         wb(1'b1, ADDR_MEM_PTR, {8'h00, m});
         wb(1'b1, ADDR_COUNTER, 32'(n * 257));
         wb(1'b0, ADDR_STATUS, 32'h0);
         wb(1'b1, ADDR_CONTROL, {25'h0, s, 1'b1, dir, w, 1'b1});
         for (int k = 0; k < 7; k++) begin
            if (k == 4) begin
               wb(1'b1, ADDR_CONTROL, {25'h0, s, 1'b1, dir, w, 1'b0});
               fire(s, 0);
               wb(1'b1, ADDR_CONTROL, {25'h0, s, 1'b1, dir, w, 1'b1});
            end
            a = dir ? m - 24'(st * (k % n)) : m + 24'(st * (k % n));
            note(s == SRC_RXF, a, w);
            fire(s, 1);
         end
         wb(1'b0, ADDR_MEM_PTR, 32'h0);
         a = dir ? m - 24'(st * (7 % n)) : m + 24'(st * (7 % n));
         cmp_reg({8'h00, a}, q);
         wb(1'b0, ADDR_COUNTER, 32'h0);
         cmp_reg(32'((n - 7 % n) * 256 + n), q);
         cmp_reg(32'h0, {31'h0, irq_o});
         wb(1'b0, ADDR_STATUS, 32'h0);
         cmp_reg(32'h2, q);
      end
      repeat (10) @(posedge clk_i);
      cmp_reg(32'h0, 32'(exp_q.size()));
      give_verdict();
   end
endmodule : tb_dma_short_addr_idle_repeat
bind dsar_channel dsar_checker chk_u (.*);
